// [src/front_panel_led_control.sv]
/*
 * front panel indicator outputs: two byte registers on host I/O ports,
 * inverted output pins and decoded indicator drives with blinking states.
 * assumes host strobes are synchronous to i_clk_sys, one cycle each.
 */
// What this block does
// - field bits 6:5 of 0x437 drive status pair
// - register outputs inverted toward indicator drivers
// - 00 solid green; 01 blinking green
// - 10 solid amber; 11 blinking amber
// - reset sets status field to 11
// - bit 4 of 0x437 lights user one
// - bit 0 of 0x435 lights user two
// - both user bits clear on reset
// - user indicators independent of each other
`timescale 1ns/10ps
module front_panel_led_control #(
    parameter int BLINK_HALF = led_pkg::BLINK_HALF_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // host I/O port
    input wire led_pkg::io_req_t i_io_req,
    output logic [7:0] o_io_rdata,
    // raw inverted output pins
    output logic [1:0] o_status_indicator_outputs_n,
    output logic o_user_indicator_one_output_n,
    output logic o_user_indicator_two_output_n,
    // decoded indicator drives, high lights the lamp
    output led_pkg::led_drive_t o_led
);

    // ****************************************
    // declarations
    // ****************************************
    logic [7:0] low_q;
    logic [7:0] low_d;
    logic [7:0] high_q;
    logic [7:0] high_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic blink_q;
    logic blink_d;
    logic [1:0] pins_q;
    logic [1:0] pins_d;
    logic user_one_n_q;
    logic user_one_n_d;
    logic user_two_n_q;
    logic user_two_n_d;
    led_pkg::led_drive_t led_q;
    led_pkg::led_drive_t led_d;
    led_pkg::status_mode_t mode_d;
    logic tick;
    logic [1:0] inv_status;
    logic hit_low;
    logic hit_high;

    assign hit_low = (i_io_req.addr == led_pkg::ADDR_LOW_BYTE);
    assign hit_high = (i_io_req.addr == led_pkg::ADDR_HIGH_BYTE);

    // ****************************************
    // blink timebase
    // ****************************************
    // free-running blink divider
    blink_divider #(
        .HALF_CYCLES(BLINK_HALF)
    ) u_blink (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .o_tick(tick)
    );

    // ****************************************
    // registers
    // ****************************************
    always_comb begin
        low_d = low_q;
        high_d = high_q;
        if (i_io_req.wr && hit_low) begin
            low_d = i_io_req.wdata;
        end
        if (i_io_req.wr && hit_high) begin
            high_d = i_io_req.wdata;
        end
    end

    // a read in the same cycle as a write returns the old value
    always_comb begin
        rdata_d = rdata_q;
        if (i_io_req.rd) begin
            if (hit_high) begin
                rdata_d = high_q;
            end else if (hit_low) begin
                rdata_d = low_q;
            end else begin
                rdata_d = led_pkg::UNMAPPED_READ;
            end
        end
    end

    always_comb begin
        blink_d = blink_q;
        if (tick) begin
            blink_d = ~blink_q;
        end
    end

    // ****************************************
    // indicator decode
    // ****************************************
    always_comb begin
        inv_status = ~high_d[led_pkg::STATUS_MSB:led_pkg::STATUS_LSB];
        pins_d = inv_status;
        user_one_n_d = ~high_d[led_pkg::USER_ONE_BIT];
        user_two_n_d = ~low_d[led_pkg::USER_TWO_BIT];
        mode_d = led_pkg::status_mode_t'(~inv_status);
        led_d.green = 1'b0;
        led_d.amber = 1'b0;
        unique case (mode_d)
            led_pkg::MODE_POWER_ON: begin
                led_d.green = 1'b1;
            end
            led_pkg::MODE_SLEEP: begin
                led_d.green = blink_d;
            end
            led_pkg::MODE_FAULT: begin
                led_d.amber = 1'b1;
            end
            led_pkg::MODE_FAULT_BLINK: begin
                led_d.amber = blink_d;
            end
        endcase
        led_d.user_one = ~user_one_n_d;
        led_d.user_two = ~user_two_n_d;
    end

    // ****************************************
    // state
    // ****************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            high_q <= led_pkg::HIGH_BYTE_RESET;
            low_q <= led_pkg::LOW_BYTE_RESET;
            rdata_q <= 8'h00;
            blink_q <= 1'b0;
            pins_q <= 2'b00;
            user_one_n_q <= 1'b1;
            user_two_n_q <= 1'b1;
            led_q <= '0;
        end else begin
            high_q <= high_d;
            low_q <= low_d;
            rdata_q <= rdata_d;
            blink_q <= blink_d;
            pins_q <= pins_d;
            user_one_n_q <= user_one_n_d;
            user_two_n_q <= user_two_n_d;
            led_q <= led_d;
        end
    end

    assign o_io_rdata = rdata_q;
    assign o_status_indicator_outputs_n = pins_q;
    assign o_user_indicator_one_output_n = user_one_n_q;
    assign o_user_indicator_two_output_n = user_two_n_q;
    assign o_led = led_q;

    // ****************************************
    // checks
    // ****************************************
    // helper: cycles since the last tick
    logic [31:0] gap_q;
    logic seen_tick_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            gap_q <= 32'h0;
            seen_tick_q <= 1'b0;
        end else if (tick) begin
            gap_q <= 32'h0;
            seen_tick_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 32'h1;
        end
    end

    sequence s_reset_pulse;
        i_rst ##1 !i_rst;
    endsequence

    sequence s_high_write;
        i_io_req.wr && hit_high;
    endsequence

    sequence s_low_write;
        i_io_req.wr && hit_low;
    endsequence

    a_status_pins: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=> (o_status_indicator_outputs_n == ~high_q[led_pkg::STATUS_MSB:led_pkg::STATUS_LSB]))
        else $error("status pins do not follow field bits");

    a_pins_inverted: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_high_write |=> (o_status_indicator_outputs_n == ~$past(i_io_req.wdata[6:5])
            && o_user_indicator_one_output_n == ~$past(i_io_req.wdata[4])))
        else $error("written value not inverted on pins");

    a_green_modes: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (high_q[6] == 1'b0) |-> (!o_led.amber && o_led.green == (high_q[5] ? blink_q : 1'b1)))
        else $error("green mode decode wrong");

    a_amber_modes: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (high_q[6] == 1'b1) |-> (!o_led.green && o_led.amber == (high_q[5] ? blink_q : 1'b1)))
        else $error("amber mode decode wrong");

    a_reset_amber: assert property (@(posedge i_clk_sys)
        s_reset_pulse |-> (high_q[6:5] == 2'b11 && !o_led.green))
        else $error("status field not 11 after reset");

    a_user_one: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_high_write |=> (o_led.user_one == $past(i_io_req.wdata[4])))
        else $error("user one does not follow bit 4");

    a_user_two: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_low_write |=> (o_led.user_two == $past(i_io_req.wdata[0])))
        else $error("user two does not follow bit 0");

    a_user_reset: assert property (@(posedge i_clk_sys)
        s_reset_pulse |-> (!o_led.user_one && !o_led.user_two
            && o_user_indicator_one_output_n && o_user_indicator_two_output_n))
        else $error("user indicators lit after reset");

    a_user_independent: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (s_low_write and !hit_high) |=> $stable(o_led.user_one) && $stable(high_q))
        else $error("low byte write disturbed user one");

    a_blink_period: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (tick && seen_tick_q) |-> (gap_q == 32'(BLINK_HALF - 1)))
        else $error("blink half period wrong");

    a_blink_toggle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        tick |=> (blink_q != $past(blink_q)))
        else $error("blink phase did not toggle on tick");

    a_blink_bound: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |-> (gap_q < 32'(BLINK_HALF)))
        else $error("blink tick missing");

    a_read_answer: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_io_req.rd && hit_high) |=> (o_io_rdata == $past(high_q)))
        else $error("read of high byte returned wrong data");

    sequence s_unmapped;
        !hit_low && !hit_high;
    endsequence

    a_low_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_io_req.rd && hit_low) |=> (o_io_rdata == $past(low_q)))
        else $error("read of low byte returned wrong data");

    a_unmapped_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (s_unmapped and i_io_req.rd) |=> (o_io_rdata == led_pkg::UNMAPPED_READ))
        else $error("unmapped read returned data");

    a_unmapped_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (s_unmapped and i_io_req.wr) |=> ($stable(high_q) && $stable(low_q)))
        else $error("unmapped write changed a register");

    a_rdata_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_io_req.rd |=> $stable(o_io_rdata))
        else $error("read data changed without a read");

    a_user_one_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=> (o_user_indicator_one_output_n == ~high_q[led_pkg::USER_ONE_BIT]))
        else $error("user one pin not inverted bit");

    a_user_two_pin: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        1'b1 |=> (o_user_indicator_two_output_n == ~low_q[led_pkg::USER_TWO_BIT]))
        else $error("user two pin not inverted bit");

    a_user_two_kept: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (s_high_write and !hit_low) |=> ($stable(o_led.user_two) && $stable(low_q)))
        else $error("high byte write disturbed user two");

    a_blink_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !tick |=> $stable(blink_q))
        else $error("blink phase moved without a tick");

    a_reset_pins: assert property (@(posedge i_clk_sys)
        s_reset_pulse |-> (o_status_indicator_outputs_n == 2'b00 && !o_led.amber))
        else $error("status pins wrong after reset");

    a_reset_low_byte: assert property (@(posedge i_clk_sys)
        s_reset_pulse |-> (low_q == '0 && !high_q[led_pkg::USER_ONE_BIT]))
        else $error("user bits not cleared by reset");

endmodule

// [src/led_pkg.sv]
/*
 * constants, types and register layout for the front panel indicator block.
 * assumes one 100 MHz system clock and 8-bit host I/O port accesses.
 */
package led_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [15:0] ADDR_LOW_BYTE = 16'h0435;
    localparam logic [15:0] ADDR_HIGH_BYTE = 16'h0437;
    localparam int STATUS_LSB = 5;
    localparam int STATUS_MSB = 6;
    localparam int USER_ONE_BIT = 4;
    localparam int USER_TWO_BIT = 0;
    localparam logic [7:0] LOW_BYTE_RESET = 8'h00;
    localparam logic [7:0] HIGH_BYTE_RESET = 8'h60;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLINK_PERIOD_MS = 1000;
    localparam int BLINK_HALF_CYCLES = (BLINK_PERIOD_MS * 1000000) / (2 * CLK_PERIOD_NS);

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_POWER_ON = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_FAULT = 2'b10,
        MODE_FAULT_BLINK = 2'b11
    } status_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic green;
        logic amber;
        logic user_one;
        logic user_two;
    } led_drive_t;

endpackage

// [src/blink_divider.sv]
/*
 * free-running divider giving a one-cycle tick every half blink period.
 * assumes a synchronous active-high reset on the same clock.
 */
`timescale 1ns/10ps
module blink_divider #(
    parameter int HALF_CYCLES = 50000000
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // tick out
    output logic o_tick
);

    localparam int W = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(HALF_CYCLES - 1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    // ****************************************
    // counter
    // ****************************************
    always_comb begin
        tick_d = (cnt_q == LAST);
        if (tick_d) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            // starts at one so the first half period after reset is as long as the rest
            cnt_q <= W'(1);
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;

    a_tick_single: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (HALF_CYCLES > 1 && tick_q) |=> !tick_q)
        else $error("divider tick lasted more than one cycle");

endmodule

// [verif/led_panel_model.sv]
/*
 * front panel lamp model: each lamp is lit while its drive is high.
 * assumes the drives come straight from the indicator block.
 */
`timescale 1ns/10ps
module led_panel_model (
    // drives from the block
    input wire led_pkg::led_drive_t i_led,
    // lamp states, high is lit
    output logic [3:0] o_lamp_lit
);
    // lamps hold no state, so a stuck drive shows at once
    assign o_lamp_lit = {i_led.green, i_led.amber, i_led.user_one, i_led.user_two};
endmodule

// [verif/tb_top.sv]
/*
 * self-checking bench for the front panel indicator block.
 * assumes host strobes one cycle wide, driven on the falling clock edge.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
    // short blink so a full period fits in a few dozen cycles
    localparam int BH = 4;
    localparam logic [15:0] LO = led_pkg::ADDR_LOW_BYTE;
    localparam logic [15:0] HI = led_pkg::ADDR_HIGH_BYTE;
    logic i_clk_sys, i_rst, user_one_n, user_two_n, snap, cnt_run, cnt_chk;
    led_pkg::io_req_t io_req;
    led_pkg::led_drive_t led;
    logic [7:0] io_rdata;
    logic [1:0] status_n;
    logic [3:0] lamp_lit;
    logic [31:0] notes[$];
    logic [31:0] lfsr_q;
    int gc, ac, miscompares, samples_checked;

    front_panel_led_control #(.BLINK_HALF(BH)) u_front_panel_led_control (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_io_req(io_req), .o_io_rdata(io_rdata),
        .o_status_indicator_outputs_n(status_n), .o_user_indicator_one_output_n(user_one_n),
        .o_user_indicator_two_output_n(user_two_n), .o_led(led));
    led_panel_model u_led_panel_model (.i_led(led), .o_lamp_lit(lamp_lit));

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] lit_cycles(logic solid, logic blink);
        return solid ? 8'(8 * BH) : (blink ? 8'(4 * BH) : 8'h00);
    endfunction

    task automatic stop_test;
        // a note never answered means a result went missing
        if (notes.size() != 0) miscompares++;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(string nm, logic [15:0] got);
        logic [31:0] n;
        // no note left: expect a value no result can show
        n = (notes.size() > 0) ? notes.pop_front() : 32'hffffffff;
        `CHK(nm, n[15:0], got & n[31:16])
    endtask

    // one bus cycle; a read notes its expected byte first
    task automatic io(logic [15:0] a, logic w, logic r, logic [7:0] d, logic [7:0] e);
        if (r) notes.push_back({16'h00ff, 8'h00, e});
        io_req = '{addr: a, wr: w, rd: r, wdata: d};
        @(negedge i_clk_sys);
    endtask

    // blinking lamps are masked here and judged by check_blink
    task automatic check_out(logic [1:0] m, logic u1, logic u2);
        logic [7:0] mask;
        mask = m[0] ? 8'hf3 : 8'hff;
        notes.push_back({8'h00, mask, 8'h00, ~m, ~u1, ~u2, m == 2'b00, m == 2'b10, u1, u2});
        snap = 1'b1;
        @(negedge i_clk_sys);
        snap = 1'b0;
    endtask

    // whole periods only, so the count is exact whatever the phase
    task automatic check_blink(logic [1:0] m);
        gc = 0;
        ac = 0;
        cnt_run = 1'b1;
        repeat (8 * BH) @(negedge i_clk_sys);
        cnt_run = 1'b0;
        notes.push_back({16'hffff, lit_cycles(m == 2'b00, m == 2'b01), lit_cycles(m == 2'b10, m == 2'b11)});
        cnt_chk = 1'b1;
        @(negedge i_clk_sys);
        cnt_chk = 1'b0;
    endtask

    task automatic do_reset;
        i_rst = 1'b1;
        io_req = '0;
        repeat (3) @(negedge i_clk_sys);
        i_rst = 1'b0;
    endtask

    task automatic check_defaults(string nm);
        io(LO, 1'b0, 1'b1, 8'h00, 8'h00);
        io(HI, 1'b0, 1'b1, 8'h00, 8'h60);
        io_req = '0;
        check_out(2'b11, 1'b0, 1'b0);
        check_blink(2'b11);
        $display("test %s done", nm);
    endtask

    // ****************************************
    // monitor
    // ****************************************
    initial begin
        forever begin
            @(posedge i_clk_sys);
            #2;
            if (cnt_run) begin
                gc += int'(lamp_lit[3]);
                ac += int'(lamp_lit[2]);
            end
            if (io_req.rd === 1'b1) check("read data", {8'h00, io_rdata});
            if (snap) check("outputs", {8'h00, status_n, user_one_n, user_two_n, lamp_lit});
            if (cnt_chk) check("lit cycles", {gc[7:0], ac[7:0]});
        end
    end

    initial begin
        repeat (2000) @(posedge i_clk_sys);
        miscompares++;
        stop_test;
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [7:0] lo;
        logic [7:0] hi;
        i_rst = 1'b1;
        io_req = '0;
        {snap, cnt_run, cnt_chk} = 3'b000;
        gc = 0;
        ac = 0;
        miscompares = 0;
        samples_checked = 0;
        lfsr_q = 32'd83989;
        @(negedge i_clk_sys);
        do_reset;
        check_defaults("reset");
        // ends in 00, as firmware leaves it once healthy
        for (int m = 3; m >= 0; m--) begin
            io(HI, 1'b1, 1'b0, {1'b0, 2'(m), 5'h00}, 8'h00);
            io_req = '0;
            check_out(2'(m), 1'b0, 1'b0);
            check_blink(2'(m));
        end
        $display("test status modes done");
        for (int k = 0; k < 4; k++) begin
            io(HI, 1'b1, 1'b0, {3'b000, k[1], 4'h0}, 8'h00);
            io(LO, 1'b1, 1'b0, {7'h00, k[0]}, 8'h00);
            io_req = '0;
            check_out(2'b00, k[1], k[0]);
        end
        $display("test user lamps done");
        repeat (4) begin
            lfsr_q = lfsr_next(lfsr_q);
            lo = lfsr_q[7:0];
            hi = lfsr_q[15:8];
            io(LO, 1'b1, 1'b0, lo, 8'h00);
            io(HI, 1'b1, 1'b0, hi, 8'h00);
            io(LO, 1'b0, 1'b1, 8'h00, lo);
            io(HI, 1'b0, 1'b1, 8'h00, hi);
            io(16'h0436, 1'b1, 1'b1, 8'hff, 8'h00);
            io(LO, 1'b1, 1'b1, ~lo, lo);
            io(LO, 1'b0, 1'b1, 8'h00, ~lo);
            io_req = '0;
            check_out(hi[6:5], hi[4], ~lo[0]);
        end
        $display("test random access done");
        do_reset;
        check_defaults("second reset");
        stop_test;
    end
endmodule
